// *** ictm_pkg.sv ***
// Constants and types for the instruction cycle timing model
// Functional notes
// - Byte/word moves count fetch, reads, writes
// - Long moves 4, 12(1/2), 36(7/2) clocks
// - Index register size never changes timing
// - Add address-calc clocks, reads, writes separately
// - Standard ops 4, 8(1/1), 12(1/2) clocks
// - Long standard to register 6, else 8
// - Exclusive-or into register: data register operand only
// - Divides at most 158 and 140 clocks
// - Multiply takes 38+2n clocks, at most 70
// - Signed multiply n counts 17-bit transitions
// - Immediate 8(2/0), 16(3/0); quick 4(1/0), long 8(1/0)
// - Single operand 4/6; set 4/6; test-set 10
// - Shifts 6+2n, 8+2n; memory shift 8(1/1)
// - Bit ops dynamic/static register clock maxima
// - Branches 10, 8, 12; subroutine 18(2/2)
// - Decrement-branch 12, 10, or 14(3/0)
// - Four-clock bus cycles; wait states added
// - Address calc 0, 4(1/0), up to 16(4/0)
package ictm_pkg;

	// ------------------------------------------------------------------
	// Timing constants
	// ------------------------------------------------------------------
	localparam int unsigned CLK_PERIOD_NS = 25;
	localparam int unsigned BUS_CYCLE_CLKS = 4;
	localparam logic [7:0]  MUL_BASE      = 8'h26; // 38 clocks
	localparam logic [7:0]  SIGNED_DIVIDE_MAX     = 8'h9e; // 158 clocks
	localparam logic [7:0]  UNSIGNED_DIVIDE_MAX   = 8'h8c; // 140 clocks
	localparam logic [7:0]  MUL_MAX               = 8'h46; // 70 clocks
	localparam logic [15:0] SIGNED_MULTIPLY_WORST = 16'h5555;

	// ------------------------------------------------------------------
	// Encodings
	// ------------------------------------------------------------------
	typedef enum logic [3:0] {
		ICTM_AM_DREG  = 4'h0,
		ICTM_AM_AREG  = 4'h1,
		ICTM_AM_IND   = 4'h2,
		ICTM_AM_POST  = 4'h3,
		ICTM_AM_PRE   = 4'h4,
		ICTM_AM_DISP  = 4'h5,
		ICTM_AM_INDEX = 4'h6,
		ICTM_AM_ABSW  = 4'h7,
		ICTM_AM_ABSL  = 4'h8,
		ICTM_AM_PCD   = 4'h9,
		ICTM_AM_PCX   = 4'ha,
		ICTM_AM_IMM   = 4'hb
	} ictm_am_t;

	typedef enum logic [4:0] {
		ICTM_OP_MOVE     = 5'h00,
		ICTM_OP_STD      = 5'h01, // add, sub, and, or, cmp to Dn or M
		ICTM_OP_STD_AREG = 5'h02,
		ICTM_OP_XOR      = 5'h03,
		ICTM_OP_SDIV     = 5'h04,
		ICTM_OP_UDIV     = 5'h05,
		ICTM_OP_SMUL     = 5'h06,
		ICTM_OP_UMUL     = 5'h07,
		ICTM_OP_IMM      = 5'h08,
		ICTM_OP_QUICK    = 5'h09,
		ICTM_OP_SINGLE   = 5'h0a,
		ICTM_OP_SETCC    = 5'h0b,
		ICTM_OP_TSTSET   = 5'h0c,
		ICTM_OP_SHIFT    = 5'h0d,
		ICTM_OP_BIT_CHANGE           = 5'h0e,
		ICTM_OP_BIT_CLEAR            = 5'h0f,
		ICTM_OP_BIT_TEST             = 5'h10,
		ICTM_OP_BCC                  = 5'h11,
		ICTM_OP_UNCONDITIONAL_BRANCH = 5'h12,
		ICTM_OP_BRANCH_TO_SUBROUTINE = 5'h13,
		ICTM_OP_DECREMENT_AND_BRANCH = 5'h14
	} ictm_op_t;

	typedef enum logic [1:0] {
		ICTM_SZ_BYTE = 2'h0,
		ICTM_SZ_WORD = 2'h1,
		ICTM_SZ_LONG = 2'h2
	} ictm_sz_t;

	// One instruction handed in for costing
	typedef struct packed {
		ictm_op_t   op;
		ictm_sz_t   size;
		ictm_am_t   src;       // source / effective address mode
		ictm_am_t   dst;       // destination mode for moves
		logic       to_mem;    // destination is memory
		logic       flag_a;    // condition true / branch taken
		logic       flag_b;    // static bit number / word displ.
		logic [5:0] count;     // shift count
		logic [15:0] operand;  // multiply source operand
		logic [7:0] wait_clks; // wait-state clocks seen on the bus
	} ictm_instr_t;

	// Figures reported per instruction
	typedef struct packed {
		logic [7:0] clocks;
		logic [3:0] reads;
		logic [3:0] writes;
	} ictm_cost_t;

endpackage : ictm_pkg

// *** ictm_timing.sv ***
// Instruction cycle-count and bus-cycle timing model
`timescale 1ns/100ps
module ictm_timing (
	// Clock, reset, enable
	input  wire logic                  i_ref_clk,
	input  wire logic                  i_reset_n,
	input  wire logic                  i_clk_en,
	// Instruction request
	input  wire logic                  i_valid,
	input  wire ictm_pkg::ictm_instr_t i_instr,
	// Result
	output logic                       o_valid,
	output ictm_pkg::ictm_cost_t       o_cost,
	output logic                       o_illegal
);

	// ------------------------------------------------------------------
	// Effective-address cost
	// ------------------------------------------------------------------
	// address calculation table, never any writes
	// index modes carry one figure for any index size
	function automatic ictm_pkg::ictm_cost_t ea_cost(
		input ictm_pkg::ictm_am_t am, input logic lng);
		ictm_pkg::ictm_cost_t c;
		c = '0;
		case (am)
			ictm_pkg::ICTM_AM_DREG,
			ictm_pkg::ICTM_AM_AREG:  c = '0;
			ictm_pkg::ICTM_AM_IND,
			ictm_pkg::ICTM_AM_POST,
			ictm_pkg::ICTM_AM_IMM:   c = lng ? {8'h08, 4'h2, 4'h0}
			                                 : {8'h04, 4'h1, 4'h0};
			ictm_pkg::ICTM_AM_PRE:   c = lng ? {8'h0a, 4'h2, 4'h0}
			                                 : {8'h06, 4'h1, 4'h0};
			ictm_pkg::ICTM_AM_DISP,
			ictm_pkg::ICTM_AM_ABSW,
			ictm_pkg::ICTM_AM_PCD:   c = lng ? {8'h0c, 4'h3, 4'h0}
			                                 : {8'h08, 4'h2, 4'h0};
			ictm_pkg::ICTM_AM_INDEX,
			ictm_pkg::ICTM_AM_PCX:   c = lng ? {8'h0e, 4'h3, 4'h0}
			                                 : {8'h0a, 4'h2, 4'h0};
			ictm_pkg::ICTM_AM_ABSL:  c = lng ? {8'h10, 4'h4, 4'h0}
			                                 : {8'h0c, 4'h3, 4'h0};
			default:                 c = '0;
		endcase
		return c;
	endfunction : ea_cost

	// Destination cost of a move: clocks and reads beyond the write
	function automatic ictm_pkg::ictm_cost_t dst_cost(
		input ictm_pkg::ictm_am_t am);
		ictm_pkg::ictm_cost_t c;
		c = '0;
		case (am)
			ictm_pkg::ICTM_AM_DREG,
			ictm_pkg::ICTM_AM_AREG:  c = {8'h00, 4'h0, 4'h0};
			ictm_pkg::ICTM_AM_IND,
			ictm_pkg::ICTM_AM_POST,
			ictm_pkg::ICTM_AM_PRE:   c = {8'h00, 4'h0, 4'h0};
			ictm_pkg::ICTM_AM_DISP,
			ictm_pkg::ICTM_AM_ABSW:  c = {8'h04, 4'h1, 4'h0};
			ictm_pkg::ICTM_AM_INDEX: c = {8'h06, 4'h1, 4'h0};
			ictm_pkg::ICTM_AM_ABSL:  c = {8'h08, 4'h2, 4'h0};
			default:                 c = '0;
		endcase
		return c;
	endfunction : dst_cost

	// ------------------------------------------------------------------
	// Multiply bit counting
	// ------------------------------------------------------------------
	logic [16:0] ext_src;
	logic [15:0] pair_diff;
	logic [4:0]  ones_cnt;
	logic [4:0]  pairs_cnt;

	assign ext_src = {i_instr.operand, 1'b0};

	// compare each adjacent pair of the 17-bit value
	genvar gi;
	generate
		for (gi = 0; gi < 16; gi++) begin : g_pair
			assign pair_diff[gi] = ext_src[gi+1] ^ ext_src[gi];
		end
	endgenerate

	always_comb begin
		ones_cnt  = '0;
		pairs_cnt = '0;
		for (int k = 0; k < 16; k++) begin
			ones_cnt  = ones_cnt + 5'(i_instr.operand[k]);
			pairs_cnt = pairs_cnt + 5'(pair_diff[k]);
		end
	end

	// ------------------------------------------------------------------
	// Cost computation
	// ------------------------------------------------------------------
	ictm_pkg::ictm_cost_t next_cost;
	logic                 next_illegal;
	logic                 next_valid;
	ictm_pkg::ictm_cost_t base;
	ictm_pkg::ictm_cost_t ea;
	ictm_pkg::ictm_cost_t dc;
	logic                 lng;
	logic                 add_ea;
	logic                 reg_src;

	always_comb begin
		lng          = (i_instr.size == ictm_pkg::ICTM_SZ_LONG);
		reg_src      = (i_instr.src == ictm_pkg::ICTM_AM_DREG) ||
		               (i_instr.src == ictm_pkg::ICTM_AM_AREG) ||
		               (i_instr.src == ictm_pkg::ICTM_AM_IMM);
		ea           = ea_cost(i_instr.src, lng);
		dc           = dst_cost(i_instr.dst);
		base         = '0;
		add_ea       = 1'b0;
		next_illegal = 1'b0;
		case (i_instr.op)
			// move: source address cost plus destination
			// long move to memory adds one extra write cycle
			ictm_pkg::ICTM_OP_MOVE: begin
				base = {8'h04 + dc.clocks, 4'h1 + dc.reads, 4'h0};
				if (i_instr.dst > ictm_pkg::ICTM_AM_AREG) begin
					base.clocks = base.clocks + (lng ? 8'h08 : 8'h04);
					base.writes = lng ? 4'h2 : 4'h1;
				end
				add_ea = 1'b1;
			end
			// standard op, register or memory destination
			// long to register: six, eight from reg/immediate
			ictm_pkg::ICTM_OP_STD: begin
				add_ea = 1'b1;
				if (i_instr.to_mem)
					base = lng ? {8'h0c, 4'h1, 4'h2}
					           : {8'h08, 4'h1, 4'h1};
				else if (lng)
					base = {(reg_src ? 8'h08 : 8'h06), 4'h1, 4'h0};
				else
					base = {8'h04, 4'h1, 4'h0};
			end
			ictm_pkg::ICTM_OP_STD_AREG: begin
				add_ea = 1'b1;
				if (lng)
					base = {(reg_src ? 8'h08 : 8'h06), 4'h1, 4'h0};
				else
					base = {8'h08, 4'h1, 4'h0};
			end
			// exclusive-or into register needs a data register
			ictm_pkg::ICTM_OP_XOR: begin
				if (i_instr.to_mem) begin
					add_ea = 1'b1;
					base = lng ? {8'h0c, 4'h1, 4'h2}
					           : {8'h08, 4'h1, 4'h1};
				end else begin
					next_illegal = (i_instr.src != ictm_pkg::ICTM_AM_DREG);
					base = {(lng ? 8'h08 : 8'h04), 4'h1, 4'h0};
				end
			end
			// divides are costed at their worst case
			ictm_pkg::ICTM_OP_SDIV: begin
				base   = {ictm_pkg::SIGNED_DIVIDE_MAX, 4'h1, 4'h0};
				add_ea = 1'b1;
			end
			ictm_pkg::ICTM_OP_UDIV: begin
				base   = {ictm_pkg::UNSIGNED_DIVIDE_MAX, 4'h1, 4'h0};
				add_ea = 1'b1;
			end
			// multiply 38 plus twice the bit count
			ictm_pkg::ICTM_OP_SMUL: begin
				base   = {ictm_pkg::MUL_BASE + {2'h0, pairs_cnt, 1'b0},
				          4'h1, 4'h0};
				add_ea = 1'b1;
			end
			ictm_pkg::ICTM_OP_UMUL: begin
				base   = {ictm_pkg::MUL_BASE + {2'h0, ones_cnt, 1'b0},
				          4'h1, 4'h0};
				add_ea = 1'b1;
			end
			ictm_pkg::ICTM_OP_IMM: begin
				if (i_instr.to_mem) begin
					add_ea = 1'b1;
					base = lng ? {8'h14, 4'h3, 4'h2}
					           : {8'h0c, 4'h2, 4'h1};
				end else
					base = lng ? {8'h10, 4'h3, 4'h0}
					           : {8'h08, 4'h2, 4'h0};
			end
			ictm_pkg::ICTM_OP_QUICK: begin
				if (i_instr.to_mem) begin
					add_ea = 1'b1;
					base = lng ? {8'h0c, 4'h1, 4'h2}
					           : {8'h08, 4'h1, 4'h1};
				end else
					base = {(lng ? 8'h08 : 8'h04), 4'h1, 4'h0};
			end
			// single operand, set on condition, test-and-set
			ictm_pkg::ICTM_OP_SINGLE: begin
				if (i_instr.to_mem) begin
					add_ea = 1'b1;
					base = lng ? {8'h0c, 4'h1, 4'h2}
					           : {8'h08, 4'h1, 4'h1};
				end else
					base = {(lng ? 8'h06 : 8'h04), 4'h1, 4'h0};
			end
			ictm_pkg::ICTM_OP_SETCC: begin
				add_ea = i_instr.to_mem;
				if (i_instr.to_mem)
					base = {8'h08, 4'h1, 4'h1};
				else
					base = {(i_instr.flag_a ? 8'h06 : 8'h04), 4'h1, 4'h0};
			end
			ictm_pkg::ICTM_OP_TSTSET: begin
				add_ea = i_instr.to_mem;
				base = i_instr.to_mem ? {8'h0a, 4'h1, 4'h1}
				                      : {8'h04, 4'h1, 4'h0};
			end
			// shift clocks grow two per position
			ictm_pkg::ICTM_OP_SHIFT: begin
				add_ea = i_instr.to_mem;
				if (i_instr.to_mem)
					base = {8'h08, 4'h1, 4'h1};
				else
					base = {(lng ? 8'h08 : 8'h06) +
					        {1'b0, i_instr.count, 1'b0}, 4'h1, 4'h0};
			end
			// bit ops; register figures are the maxima
			ictm_pkg::ICTM_OP_BIT_CHANGE,
			ictm_pkg::ICTM_OP_BIT_CLEAR,
			ictm_pkg::ICTM_OP_BIT_TEST: begin
				add_ea = i_instr.to_mem;
				if (i_instr.to_mem)
					base = (i_instr.op == ictm_pkg::ICTM_OP_BIT_TEST)
					     ? {(i_instr.flag_b ? 8'h08 : 8'h04),
					        (i_instr.flag_b ? 4'h2 : 4'h1), 4'h0}
					     : {(i_instr.flag_b ? 8'h0c : 8'h08),
					        (i_instr.flag_b ? 4'h2 : 4'h1), 4'h1};
				else begin
					base = {(i_instr.flag_b ? 8'h0c : 8'h08),
					        (i_instr.flag_b ? 4'h2 : 4'h1), 4'h0};
					if (i_instr.op == ictm_pkg::ICTM_OP_BIT_CLEAR)
						base.clocks = base.clocks + 8'h02;
					if (i_instr.op == ictm_pkg::ICTM_OP_BIT_TEST)
						base.clocks = base.clocks - 8'h02;
				end
			end
			// branch taken, not taken, always, subroutine
			ictm_pkg::ICTM_OP_BCC: begin
				if (i_instr.flag_a)
					base = {8'h0a, 4'h2, 4'h0};
				else
					base = i_instr.flag_b ? {8'h0c, 4'h2, 4'h0}
					                      : {8'h08, 4'h1, 4'h0};
			end
			ictm_pkg::ICTM_OP_UNCONDITIONAL_BRANCH:
				base = {8'h0a, 4'h2, 4'h0};
			ictm_pkg::ICTM_OP_BRANCH_TO_SUBROUTINE:
				base = {8'h12, 4'h2, 4'h2};
			// condition true, loop taken, counter expired
			ictm_pkg::ICTM_OP_DECREMENT_AND_BRANCH: begin
				if (i_instr.flag_a)
					base = {8'h0c, 4'h2, 4'h0};
				else
					base = i_instr.flag_b ? {8'h0e, 4'h3, 4'h0}
					                      : {8'h0a, 4'h2, 4'h0};
			end
			default: next_illegal = 1'b1;
		endcase
		// address-calculation figures added field by field
		next_cost = base;
		if (add_ea) begin
			next_cost.clocks = base.clocks + ea.clocks;
			next_cost.reads  = base.reads + ea.reads;
			next_cost.writes = base.writes + ea.writes;
		end
		next_cost.clocks = next_cost.clocks + i_instr.wait_clks;
		next_valid = i_valid;
	end

	// ------------------------------------------------------------------
	// Result registers
	// ------------------------------------------------------------------
	// one result per instruction, one cycle after request
	always_ff @(posedge i_ref_clk) begin
		if (!i_reset_n) begin
			o_valid   <= 1'b0;
			o_cost    <= '0;
			o_illegal <= 1'b0;
		end else if (i_clk_en) begin
			o_valid <= next_valid;
			if (next_valid) begin
				o_cost    <= next_cost;
				o_illegal <= next_illegal;
			end
		end
	end

	// ------------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------------
	default clocking cb @(posedge i_ref_clk); endclocking
	default disable iff (!i_reset_n);

	sequence s_mul_req;
		i_clk_en && i_valid && (i_instr.op == ictm_pkg::ICTM_OP_UMUL ||
		                        i_instr.op == ictm_pkg::ICTM_OP_SMUL);
	endsequence

	a_reg_move_cost: assert property (
		i_clk_en && i_valid && i_instr.op == ictm_pkg::ICTM_OP_MOVE &&
		i_instr.src == ictm_pkg::ICTM_AM_DREG &&
		i_instr.dst == ictm_pkg::ICTM_AM_DREG && i_instr.wait_clks == 0
		|=> o_cost == {8'h04, 4'h1, 4'h0})
		else $error("register move cost wrong");

	a_long_move_max: assert property (
		i_clk_en && i_valid && i_instr.op == ictm_pkg::ICTM_OP_MOVE &&
		i_instr.size == ictm_pkg::ICTM_SZ_LONG &&
		i_instr.src == ictm_pkg::ICTM_AM_ABSL &&
		i_instr.dst == ictm_pkg::ICTM_AM_ABSL && i_instr.wait_clks == 0
		|=> o_cost == {8'h24, 4'h7, 4'h2})
		else $error("long absolute move cost wrong");

	a_mul_bound: assert property (
		s_mul_req and (i_instr.wait_clks == 0) and
		(i_instr.src == ictm_pkg::ICTM_AM_DREG)
		|=> o_cost.clocks <= ictm_pkg::MUL_MAX && o_cost.clocks[0] == 1'b0)
		else $error("multiply beyond maximum");

	a_smul_worst: assert property (
		s_mul_req and (i_instr.op == ictm_pkg::ICTM_OP_SMUL) and
		(i_instr.operand == ictm_pkg::SIGNED_MULTIPLY_WORST) and
		(i_instr.src == ictm_pkg::ICTM_AM_DREG) and (i_instr.wait_clks == 0)
		|=> o_cost.clocks == ictm_pkg::MUL_MAX)
		else $error("signed multiply worst case wrong");

	a_xor_mode: assert property (
		i_clk_en && i_valid && i_instr.op == ictm_pkg::ICTM_OP_XOR &&
		!i_instr.to_mem && i_instr.src != ictm_pkg::ICTM_AM_DREG
		|=> o_illegal)
		else $error("exclusive-or mode not refused");

	a_div_bound: assert property (
		i_clk_en && i_valid && i_instr.op == ictm_pkg::ICTM_OP_SDIV &&
		i_instr.src == ictm_pkg::ICTM_AM_DREG && i_instr.wait_clks == 0
		|=> o_cost == {ictm_pkg::SIGNED_DIVIDE_MAX, 4'h1, 4'h0})
		else $error("signed divide cost wrong");

	a_decrement_and_branch_expire: assert property (
		i_clk_en && i_valid &&
		i_instr.op == ictm_pkg::ICTM_OP_DECREMENT_AND_BRANCH &&
		!i_instr.flag_a && i_instr.flag_b && i_instr.wait_clks == 0
		|=> o_cost == {8'h0e, 4'h3, 4'h0})
		else $error("decrement-branch expiry cost wrong");

	a_bsr_cost: assert property (
		i_clk_en && i_valid &&
		i_instr.op == ictm_pkg::ICTM_OP_BRANCH_TO_SUBROUTINE &&
		i_instr.wait_clks == 0
		|=> o_cost == {8'h12, 4'h2, 4'h2})
		else $error("subroutine branch cost wrong");

	a_valid_follow: assert property (
		i_clk_en |=> o_valid == $past(i_valid))
		else $error("result strobe not one cycle after request");

endmodule : ictm_timing

// *** ictm_bus_mem.sv ***
// Bus memory model that stretches every bus cycle by wait clocks
`timescale 1ns/100ps
module ictm_bus_mem (
	// Bus cycle counts of the instruction
	input  wire logic [3:0] i_reads,
	input  wire logic [3:0] i_writes,
	// Wait clocks this memory adds to each cycle
	input  wire logic [1:0] i_wait_per,
	// Clocks beyond the four-clock cycles
	output logic      [7:0] o_wait_clks
);
	// wait states added
	// Every read and write is stretched alike, so a slow memory costs
	// in proportion to bus traffic; each cycle grows to four plus i_wait_per clocks
	always_comb begin
		o_wait_clks = 8'(({4'h0, i_reads} + {4'h0, i_writes})
			* {6'h00, i_wait_per});
	end
endmodule : ictm_bus_mem

// *** testbench.sv ***
// Self-checking bench for the instruction cycle timing model
`timescale 1ns/100ps
module testbench;
	// ----------------------------------------------------------------
	// Signals
	// ----------------------------------------------------------------
	logic                  i_ref_clk;
	logic                  i_reset_n;
	logic                  i_clk_en;
	logic                  i_valid;
	ictm_pkg::ictm_instr_t i_instr;
	logic                  o_valid;
	ictm_pkg::ictm_cost_t  o_cost;
	logic                  o_illegal;
	ictm_pkg::ictm_instr_t ins;
	ictm_pkg::ictm_cost_t  held;
	logic [3:0]            pm_reads;
	logic [3:0]            pm_writes;
	logic [1:0]            pm_wait_per;
	logic [7:0]            pm_wait_clks;
	int                    err_count;
	int                    cmp_count;
	int                    i;

	ictm_timing ictm_timing_i (
		.i_ref_clk (i_ref_clk),
		.i_reset_n (i_reset_n),
		.i_clk_en  (i_clk_en),
		.i_valid   (i_valid),
		.i_instr   (i_instr),
		.o_valid   (o_valid),
		.o_cost    (o_cost),
		.o_illegal (o_illegal)
	);

	ictm_bus_mem ictm_bus_mem_i (
		.i_reads     (pm_reads),
		.i_writes    (pm_writes),
		.i_wait_per  (pm_wait_per),
		.o_wait_clks (pm_wait_clks)
	);

	// 40 MHz clock
	initial i_ref_clk = 1'b0;
	always #12.5 i_ref_clk = ~i_ref_clk;

	// ----------------------------------------------------------------
	// Checking and closing
	// ----------------------------------------------------------------
	task automatic check(input string what, input logic [15:0] seen,
		input logic [15:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			err_count++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
		end
	endtask : check

	task automatic close_out;
		$display("Mismatches %0d, comparisons %0d", err_count, cmp_count);
		if (err_count == 0 && cmp_count > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask : close_out

	// ----------------------------------------------------------------
	// Expected figures
	// ----------------------------------------------------------------
	// Address calculation as {clocks, reads}; long adds one bus cycle except for register modes
	function automatic logic [11:0] ea(input ictm_pkg::ictm_am_t am,
		input logic lng);
		logic [11:0] r;
		case (am)
			ictm_pkg::ICTM_AM_DREG, ictm_pkg::ICTM_AM_AREG: return 12'h000;
			ictm_pkg::ICTM_AM_PRE: r = 12'h061;
			ictm_pkg::ICTM_AM_DISP, ictm_pkg::ICTM_AM_ABSW,
			ictm_pkg::ICTM_AM_PCD: r = 12'h082;
			ictm_pkg::ICTM_AM_INDEX, ictm_pkg::ICTM_AM_PCX: r = 12'h0a2;
			ictm_pkg::ICTM_AM_ABSL: r = 12'h0c3;
			default: r = 12'h041;
		endcase
		return lng ? r + 12'h041 : r;
	endfunction : ea

	// Base cost before wait states, as {clocks, reads, writes}
	function automatic ictm_pkg::ictm_cost_t expect_of(
		input ictm_pkg::ictm_instr_t t);
		logic        lng;
		logic [11:0] e;
		logic [11:0] d;
		logic [7:0]  c;
		logic [3:0]  r;
		logic [3:0]  w;
		logic [16:0] s;
		lng = (t.size == ictm_pkg::ICTM_SZ_LONG);
		e = ea(t.src, lng);
		s = {t.operand, 1'b0};
		{c, r, w} = 16'h0410;
		case (t.op)
			ictm_pkg::ICTM_OP_MOVE: if (t.dst > ictm_pkg::ICTM_AM_AREG) begin
				// Destination pays its address words, operand goes out as writes
				d = ea(t.dst == ictm_pkg::ICTM_AM_PRE ? ictm_pkg::ICTM_AM_IND
					: t.dst, 1'b0);
				{c, r} = {8'h04 + d[11:4] + (lng ? 8'h04 : 8'h00), d[3:0]};
				w = lng ? 4'h2 : 4'h1;
			end
			ictm_pkg::ICTM_OP_STD: if (t.to_mem) begin
				{c, r, w} = lng ? 16'h0c12 : 16'h0811;
			end else if (lng) begin
				c = (t.src <= ictm_pkg::ICTM_AM_AREG
					|| t.src == ictm_pkg::ICTM_AM_IMM) ? 8'h08 : 8'h06;
			end
			// Address-register destination: eight, long six unless reg/imm
			ictm_pkg::ICTM_OP_STD_AREG: c = (!lng
				|| t.src <= ictm_pkg::ICTM_AM_AREG
				|| t.src == ictm_pkg::ICTM_AM_IMM) ? 8'h08 : 8'h06;
			ictm_pkg::ICTM_OP_XOR: c = lng ? 8'h08 : 8'h04;
			ictm_pkg::ICTM_OP_SDIV: c = ictm_pkg::SIGNED_DIVIDE_MAX;
			ictm_pkg::ICTM_OP_UDIV: c = ictm_pkg::UNSIGNED_DIVIDE_MAX;
			ictm_pkg::ICTM_OP_SMUL: c = ictm_pkg::MUL_BASE
				+ 8'(2 * $countones(s[16:1] ^ s[15:0]));
			ictm_pkg::ICTM_OP_UMUL: c = ictm_pkg::MUL_BASE
				+ 8'(2 * $countones(t.operand));
			ictm_pkg::ICTM_OP_IMM: {c, r} = lng ? 12'h103 : 12'h082;
			ictm_pkg::ICTM_OP_SINGLE: c = lng ? 8'h06 : 8'h04;
			ictm_pkg::ICTM_OP_SETCC: c = t.flag_a ? 8'h06 : 8'h04;
			ictm_pkg::ICTM_OP_TSTSET: {c, r, w} = 16'h0a11;
			ictm_pkg::ICTM_OP_SHIFT: if (t.to_mem) begin
				{c, r, w} = 16'h0811;
			end else begin
				c = (lng ? 8'h08 : 8'h06) + {1'b0, t.count, 1'b0};
			end
			ictm_pkg::ICTM_OP_BIT_CHANGE:
				{c, r} = t.flag_b ? 12'h0c2 : 12'h081;
			ictm_pkg::ICTM_OP_BIT_CLEAR:
				{c, r} = t.flag_b ? 12'h0e2 : 12'h0a1;
			ictm_pkg::ICTM_OP_BIT_TEST:
				{c, r} = t.flag_b ? 12'h0a2 : 12'h061;
			ictm_pkg::ICTM_OP_BCC: {c, r} = t.flag_a ? 12'h0a2
				: (t.flag_b ? 12'h0c2 : 12'h081);
			ictm_pkg::ICTM_OP_UNCONDITIONAL_BRANCH:
				{c, r} = 12'h0a2;
			ictm_pkg::ICTM_OP_BRANCH_TO_SUBROUTINE:
				{c, r, w} = 16'h1222;
			ictm_pkg::ICTM_OP_DECREMENT_AND_BRANCH:
				{c, r} = t.flag_a ? 12'h0c2
				: (t.flag_b ? 12'h0e3 : 12'h0a2);
			default: w = 4'h0;
		endcase
		return {c + e[11:4], r + e[3:0], w};
	endfunction : expect_of

	// ----------------------------------------------------------------
	// Stimulus tasks; entered and left one step after a clock edge
	// ----------------------------------------------------------------
	// Random instruction of one class with fields the class accepts
	task automatic rnd(input int op);
		ictm_pkg::ictm_am_t m;
		m = ictm_pkg::ictm_am_t'($urandom_range(8, 2));
		ins = '0;
		ins.op = ictm_pkg::ictm_op_t'(op);
		ins.size = ictm_pkg::ictm_sz_t'($urandom_range(2, 0));
		ins.flag_a = 1'($urandom);
		ins.flag_b = 1'($urandom);
		ins.count = 6'($urandom);
		ins.operand = 16'($urandom);
		ins.to_mem = 1'($urandom);
		case (ins.op)
			ictm_pkg::ICTM_OP_MOVE: begin
				ins.src = ictm_pkg::ictm_am_t'($urandom_range(11, 0));
				ins.dst = ictm_pkg::ictm_am_t'($urandom_range(8, 0));
				ins.to_mem = (ins.dst > ictm_pkg::ICTM_AM_AREG);
			end
			ictm_pkg::ICTM_OP_STD: ins.src = ins.to_mem ? m
				: ictm_pkg::ictm_am_t'($urandom_range(11, 0));
			ictm_pkg::ICTM_OP_SDIV, ictm_pkg::ICTM_OP_UDIV,
			ictm_pkg::ICTM_OP_SMUL, ictm_pkg::ICTM_OP_UMUL: begin
				ins.src = ictm_pkg::ictm_am_t'($urandom_range(11, 0));
				ins.size = ictm_pkg::ICTM_SZ_WORD;
				ins.to_mem = 1'b0;
			end
			ictm_pkg::ICTM_OP_TSTSET: {ins.size, ins.to_mem, ins.src} =
				{ictm_pkg::ICTM_SZ_BYTE, 1'b1, m};
			ictm_pkg::ICTM_OP_SHIFT: if (ins.to_mem) begin
				{ins.size, ins.src} = {ictm_pkg::ICTM_SZ_WORD, m};
			end
			ictm_pkg::ICTM_OP_QUICK: {ins.size, ins.to_mem} =
				{ictm_pkg::ictm_sz_t'($urandom_range(1, 0)), 1'b0};
			default: ins.to_mem = 1'b0;
		endcase
	endtask : rnd

	// Issue ins with memory wait setting wp, then check the answer
	task automatic go(input logic ill, input logic [1:0] wp);
		ictm_pkg::ictm_cost_t x;
		x = expect_of(ins);
		{pm_reads, pm_writes, pm_wait_per} = {x.reads, x.writes, wp};
		#1;
		ins.wait_clks = pm_wait_clks;
		x.clocks = x.clocks + pm_wait_clks;
		held = x;
		i_instr = ins;
		i_valid = 1'b1;
		@(posedge i_ref_clk);
		#1;
		check("valid", {15'h0000, o_valid}, 16'h0001);
		check("illegal", {15'h0000, o_illegal}, {15'h0000, ill});
		if (!ill) check("cost", o_cost, x);
	endtask : go

	// Watchdog against a hung handshake
	initial begin
		repeat (20000) @(posedge i_ref_clk);
		err_count++;
		close_out;
	end

	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial begin
		{i_reset_n, i_clk_en, i_valid, i_instr, ins} = '0;
		{pm_reads, pm_writes, pm_wait_per} = '0;
		err_count = 0;
		cmp_count = 0;
		void'($urandom(70));
		i_clk_en = 1'b1;
		repeat (4) @(posedge i_ref_clk);
		#1;
		check("reset valid", {15'h0000, o_valid}, 16'h0000);
		check("reset cost", o_cost, 16'h0000);
		#1;
		i_reset_n = 1'b1;
		@(posedge i_ref_clk);
		#1;
		// Table corners of moves, no wait states
		rnd(0);
		{ins.size, ins.src, ins.dst} = {ictm_pkg::ICTM_SZ_LONG,
			ictm_pkg::ICTM_AM_ABSL, ictm_pkg::ICTM_AM_ABSL};
		go(1'b0, 2'h0);
		check("long absl", o_cost, 16'h2472);
		ins.size = ictm_pkg::ICTM_SZ_BYTE;
		go(1'b0, 2'h0);
		check("byte absl", o_cost, 16'h1c61);
		{ins.size, ins.src, ins.dst} = {ictm_pkg::ICTM_SZ_LONG,
			ictm_pkg::ICTM_AM_DREG, ictm_pkg::ICTM_AM_IND};
		go(1'b0, 2'h0);
		check("long to ind", o_cost, 16'h0c12);
		{ins.dst, ins.to_mem} = {ictm_pkg::ICTM_AM_DREG, 1'b0};
		go(1'b0, 2'h0);
		check("reg to reg", o_cost, 16'h0410);
		// Multiply and divide extremes from a data register
		rnd(6);
		{ins.src, ins.operand} = {ictm_pkg::ICTM_AM_DREG, 16'h5555};
		go(1'b0, 2'h0);
		check("signed mul worst", o_cost, 16'h4610);
		ins.operand = 16'h0000;
		go(1'b0, 2'h0);
		check("signed mul zero", o_cost, 16'h2610);
		rnd(4);
		ins.src = ictm_pkg::ICTM_AM_DREG;
		go(1'b0, 2'h0);
		check("signed div", o_cost, 16'h9e10);
		// Exclusive-or from memory into a register and an undefined class are flagged
		rnd(3);
		ins.src = ictm_pkg::ICTM_AM_IND;
		go(1'b1, 2'h0);
		rnd(31);
		go(1'b1, 2'h0);
		// Every class once, then a long random run back to back
		for (i = 0; i <= 20; i++) begin
			rnd(i);
			go(1'b0, 2'($urandom));
		end
		for (i = 0; i < 600; i++) begin
			rnd($urandom_range(20, 0));
			go(1'b0, 2'($urandom));
		end
		// Disabled clock holds everything, even with a request up
		#1;
		i_clk_en = 1'b0;
		@(posedge i_ref_clk);
		#1;
		check("frozen cost", o_cost, held);
		check("frozen valid", {15'h0000, o_valid}, 16'h0001);
		#1;
		{i_clk_en, i_valid} = 2'b10;
		@(posedge i_ref_clk);
		#1;
		check("idle valid", {15'h0000, o_valid}, 16'h0000);
		check("idle cost", o_cost, held);
		// Reset in mid-run clears the result
		#1;
		{i_reset_n, i_valid} = 2'b01;
		@(posedge i_ref_clk);
		#1;
		check("rerun valid", {15'h0000, o_valid}, 16'h0000);
		check("rerun cost", o_cost, 16'h0000);
		#1;
		{i_reset_n, i_valid} = 2'b10;
		@(posedge i_ref_clk);
		#1;
		rnd(13);
		go(1'b0, 2'h3);
		close_out;
	end
endmodule : testbench
